// ### hdl/btf_top.sv
// Branch trace queues with an AXI4-Lite register slave.
// Assumes branch events come from pipeline logic on aclk, one pulse each.
`timescale 1ns/100ps
`default_nettype none
module btf_top
   import btf_pkg::*;
#(
   parameter int DEPTH = BTF_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic branch_strobe,
   input wire logic [BTF_ADDR_W-1:0] branch_source,
   input wire logic [BTF_ADDR_W-1:0] branch_target,
   input wire logic [BTF_PTR_W-1:0] branch_pointer,
   input wire logic target_fetch_strobe,
   input wire logic [BTF_BUS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [BTF_BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      btf_wr_state_e wr_state;
      logic [BTF_BUS_ADDR_W-1:0] wr_addr;
      logic [1:0] bresp;
      btf_rd_state_e rd_state;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } btf_top_s;

   btf_top_s r;
   btf_top_s next_r;

   btf_trace_if trace ();

   logic [DEPTH-1:0][BTF_ADDR_W-1:0] source_q;
   logic [DEPTH-1:0][BTF_ADDR_W-1:0] target_q;
   logic [DEPTH-1:0][BTF_PTR_W-1:0] pointer_q;

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic [BTF_BUS_ADDR_W-1:0] wr_addr_now;
   btf_group_e rd_grp;
   logic [BTF_IDX_W-1:0] rd_idx;
   btf_group_e wr_grp;
   logic [31:0] rd_word;
   logic [DEPTH-1:0] clr_src;
   logic [DEPTH-1:0] clr_tgt;

   // Unused bus fields: protection and write contents have no effect
   logic unused_bits;
   assign unused_bits = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb};

   ////////////////////////////////////////////////////////////////////////////
   // Trace capture

   assign trace.shift = branch_strobe;
   assign trace.fetch = target_fetch_strobe;
   assign trace.source = branch_source;
   assign trace.target = branch_target;
   assign trace.pointer = branch_pointer;
   assign trace.clear_source = clr_src;
   assign trace.clear_target = clr_tgt;

   btf_queue #(
      .WIDTH(BTF_ADDR_W),
      .DEPTH(DEPTH)
   ) u_source_queue (
      .aclk(aclk),
      .shift(trace.shift),
      .din(trace.source),
      .dout(source_q)
   );

   btf_queue #(
      .WIDTH(BTF_ADDR_W),
      .DEPTH(DEPTH)
   ) u_target_queue (
      .aclk(aclk),
      .shift(trace.shift),
      .din(trace.target),
      .dout(target_q)
   );

   btf_queue #(
      .WIDTH(BTF_PTR_W),
      .DEPTH(DEPTH)
   ) u_pointer_queue (
      .aclk(aclk),
      .shift(trace.shift),
      .din(trace.pointer),
      .dout(pointer_q)
   );

   btf_valid_queue #(
      .DEPTH(DEPTH)
   ) u_valid_queue (
      .aclk(aclk),
      .aresetn(aresetn),
      .trace(trace.flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Handshakes

   assign s_axi_awready = (r.wr_state == BTF_WR_IDLE) || (r.wr_state == BTF_WR_HAVE_DATA);
   assign s_axi_wready = (r.wr_state == BTF_WR_IDLE) || (r.wr_state == BTF_WR_HAVE_ADDR);
   assign s_axi_bvalid = (r.wr_state == BTF_WR_RESP);
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = (r.rd_state == BTF_RD_IDLE);
   assign s_axi_rvalid = (r.rd_state == BTF_RD_RESP);
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   assign rd_grp = btf_group(s_axi_araddr);
   assign rd_idx = btf_index(s_axi_araddr);

   always_comb begin
      rd_word = BTF_READ_ZERO;
      clr_src = '0;
      clr_tgt = '0;
      case (rd_grp)
         BTF_GRP_FLAGS: begin
            rd_word = {BTF_FLAGS_PAD,
                       trace.source_valid[rd_idx],
                       pointer_q[rd_idx],
                       BTF_RSVD_HI,
                       trace.target_valid[rd_idx],
                       BTF_RSVD_LO};
         end
         BTF_GRP_SOURCE: begin
            rd_word = source_q[rd_idx];
            clr_src[rd_idx] = ar_hs;
         end
         BTF_GRP_TARGET: begin
            rd_word = target_q[rd_idx];
            clr_tgt[rd_idx] = ar_hs;
         end
         default: begin
            rd_word = BTF_READ_ZERO;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus state

   assign wr_addr_now = (r.wr_state == BTF_WR_HAVE_ADDR) ? r.wr_addr : s_axi_awaddr;
   assign wr_grp = btf_group(wr_addr_now);

   always_comb begin
      next_r = r;
      case (r.wr_state)
         BTF_WR_IDLE: begin
            if (aw_hs && w_hs) begin
               next_r.wr_state = BTF_WR_RESP;
            end else if (aw_hs) begin
               next_r.wr_state = BTF_WR_HAVE_ADDR;
            end else if (w_hs) begin
               next_r.wr_state = BTF_WR_HAVE_DATA;
            end
            if (aw_hs) begin
               next_r.wr_addr = s_axi_awaddr;
            end
         end
         BTF_WR_HAVE_ADDR: begin
            if (w_hs) begin
               next_r.wr_state = BTF_WR_RESP;
            end
         end
         BTF_WR_HAVE_DATA: begin
            if (aw_hs) begin
               next_r.wr_addr = s_axi_awaddr;
               next_r.wr_state = BTF_WR_RESP;
            end
         end
         BTF_WR_RESP: begin
            if (s_axi_bready) begin
               next_r.wr_state = BTF_WR_IDLE;
            end
         end
         default: begin
            next_r.wr_state = BTF_WR_IDLE;
         end
      endcase
      // Writes store nothing; mapped addresses answer OKAY
      if (next_r.wr_state == BTF_WR_RESP && r.wr_state != BTF_WR_RESP) begin
         next_r.bresp = (wr_grp == BTF_GRP_NONE) ? BTF_RESP_SLVERR : BTF_RESP_OKAY;
      end
      case (r.rd_state)
         BTF_RD_IDLE: begin
            if (ar_hs) begin
               next_r.rd_state = BTF_RD_RESP;
               next_r.rdata = rd_word;
               next_r.rresp = (rd_grp == BTF_GRP_NONE) ? BTF_RESP_SLVERR : BTF_RESP_OKAY;
            end
         end
         BTF_RD_RESP: begin
            if (s_axi_rready) begin
               next_r.rd_state = BTF_RD_IDLE;
            end
         end
         default: begin
            next_r.rd_state = BTF_RD_IDLE;
         end
      endcase
      if (!aresetn) begin
         next_r.wr_state = BTF_WR_IDLE;
         next_r.wr_addr = '0;
         next_r.bresp = BTF_RESP_OKAY;
         next_r.rd_state = BTF_RD_IDLE;
         next_r.rdata = BTF_READ_ZERO;
         next_r.rresp = BTF_RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      r <= next_r;
   end
endmodule
`default_nettype wire

// ### inc/btf_pkg.sv
// Constants, types and register map of the branch trace queues.
// Assumes one 250 MHz clock and a 32-bit AXI4-Lite register port.
package btf_pkg;

   localparam int BTF_DEPTH = 4;
   localparam int BTF_ADDR_W = 32;
   localparam int BTF_PTR_W = 3;
   localparam int BTF_IDX_W = 2;
   localparam int BTF_BUS_ADDR_W = 8;

   localparam logic [7:0] BTF_FLAGS_BASE = 8'h00;
   localparam logic [7:0] BTF_SOURCE_BASE = 8'h10;
   localparam logic [7:0] BTF_TARGET_BASE = 8'h20;

   localparam int BTF_SRC_VALID_BIT = 15;
   localparam int BTF_PTR_HI = 14;
   localparam int BTF_PTR_LO = 12;
   localparam int BTF_TGT_VALID_BIT = 7;
   localparam logic [3:0] BTF_RSVD_HI = 4'h0;
   localparam logic [6:0] BTF_RSVD_LO = 7'h00;
   localparam logic [15:0] BTF_FLAGS_PAD = 16'h0000;

   localparam logic [1:0] BTF_RESP_OKAY = 2'h0;
   localparam logic [1:0] BTF_RESP_SLVERR = 2'h2;
   localparam logic [31:0] BTF_READ_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      BTF_GRP_FLAGS = 2'b00,
      BTF_GRP_SOURCE = 2'b01,
      BTF_GRP_TARGET = 2'b10,
      BTF_GRP_NONE = 2'b11
   } btf_group_e;

   typedef enum logic [1:0] {
      BTF_WR_IDLE = 2'b00,
      BTF_WR_HAVE_ADDR = 2'b01,
      BTF_WR_HAVE_DATA = 2'b10,
      BTF_WR_RESP = 2'b11
   } btf_wr_state_e;

   typedef enum logic {
      BTF_RD_IDLE = 1'b0,
      BTF_RD_RESP = 1'b1
   } btf_rd_state_e;

   // Register group of a byte address
   function automatic btf_group_e btf_group(input logic [BTF_BUS_ADDR_W-1:0] a);
      btf_group_e g;
      g = BTF_GRP_NONE;
      if (a[7:4] == BTF_FLAGS_BASE[7:4]) begin
         g = BTF_GRP_FLAGS;
      end else if (a[7:4] == BTF_SOURCE_BASE[7:4]) begin
         g = BTF_GRP_SOURCE;
      end else if (a[7:4] == BTF_TARGET_BASE[7:4]) begin
         g = BTF_GRP_TARGET;
      end
      return g;
   endfunction

   // Queue entry selected by a byte address
   function automatic logic [BTF_IDX_W-1:0] btf_index(input logic [BTF_BUS_ADDR_W-1:0] a);
      return a[3:2];
   endfunction

endpackage

// ### inc/btf_trace_if.sv
// Carrier between the trace top and its queue modules.
// Assumes one clock shared by all users.
`timescale 1ns/100ps
`default_nettype none
interface btf_trace_if;
   import btf_pkg::*;
   logic shift;
   logic fetch;
   logic [BTF_ADDR_W-1:0] source;
   logic [BTF_ADDR_W-1:0] target;
   logic [BTF_PTR_W-1:0] pointer;
   logic [BTF_DEPTH-1:0] clear_source;
   logic [BTF_DEPTH-1:0] clear_target;
   logic [BTF_DEPTH-1:0] source_valid;
   logic [BTF_DEPTH-1:0] target_valid;
   modport ctrl (
      output shift, fetch, source, target, pointer, clear_source, clear_target,
      input source_valid, target_valid
   );
   modport flags (
      input shift, fetch, clear_source, clear_target,
      output source_valid, target_valid
   );
endinterface
`default_nettype wire

// ### hdl/btf_queue.sv
// Shift queue of unreset data entries, newest at index 0.
// Assumes shift is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
module btf_queue
   import btf_pkg::*;
#(
   parameter int WIDTH = BTF_ADDR_W,
   parameter int DEPTH = BTF_DEPTH
) (
   input wire logic aclk,
   input wire logic shift,
   input wire logic [WIDTH-1:0] din,
   output logic [DEPTH-1:0][WIDTH-1:0] dout
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] entry;
   } btf_queue_s;

   btf_queue_s r;
   btf_queue_s next_r;

   always_comb begin
      next_r = r;
      if (shift) begin
         next_r.entry[0] = din;
         for (int i = 1; i < DEPTH; i++) begin
            next_r.entry[i] = r.entry[i-1];
         end
      end
   end

   // No reset: each entry stays undefined until a branch shifts data into it
   always_ff @(posedge aclk) begin
      r <= next_r;
   end

   assign dout = r.entry;
endmodule
`default_nettype wire

// ### hdl/btf_valid_queue.sv
// Validity flags of the trace queue: shift, set on target fetch, clear on read.
// Assumes pulses on the same clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module btf_valid_queue
   import btf_pkg::*;
#(
   parameter int DEPTH = BTF_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   btf_trace_if.flags trace
);
   typedef struct packed {
      logic [DEPTH-1:0] src;
      logic [DEPTH-1:0] tgt;
   } btf_valid_s;

   btf_valid_s r;
   btf_valid_s next_r;
   logic [DEPTH-1:0] src_kept;
   logic [DEPTH-1:0] tgt_kept;

   always_comb begin
      next_r = r;
      src_kept = r.src & ~trace.clear_source;
      tgt_kept = r.tgt & ~trace.clear_target;
      if (trace.shift) begin
         next_r.src = {src_kept[DEPTH-2:0], 1'b0};
         next_r.tgt = {tgt_kept[DEPTH-2:0], 1'b0};
      end else begin
         next_r.src = src_kept;
         next_r.tgt = tgt_kept;
      end
      // Set wins over a read clear in the same cycle
      if (trace.fetch) begin
         next_r.src[0] = 1'b1;
         next_r.tgt[0] = 1'b1;
      end
      if (!aresetn) begin
         next_r.src = '0;
         next_r.tgt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      r <= next_r;
   end

   assign trace.source_valid = r.src;
   assign trace.target_valid = r.tgt;
endmodule
`default_nettype wire

// ### testbench/btf_top_monitor.sv
// Checker of the trace register read port and branch inputs of btf_top.
// Assumes it is bound into btf_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module btf_top_monitor
   import btf_pkg::*;
#(
   parameter int DEPTH = BTF_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic branch_strobe,
   input wire logic [BTF_ADDR_W-1:0] branch_source,
   input wire logic [BTF_ADDR_W-1:0] branch_target,
   input wire logic [BTF_PTR_W-1:0] branch_pointer,
   input wire logic target_fetch_strobe,
   input wire logic [BTF_BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid
);
////////////////////////////////////////
   logic [DEPTH-1:0] ps;
   logic [DEPTH-1:0] pt;
   logic seen, hv, fs, ft, arh;
   logic [31:0] ls, lt, es, et;
   logic [2:0] lp, ep;
   logic [3:0] grp;
   assign arh = s_axi_arvalid & s_axi_arready;
   assign grp = s_axi_araddr[7:4];
   // Expected entry 0 as seen at the read edge
   always_ff @(posedge aclk) begin
      if (branch_strobe) begin
         ls <= branch_source;
         lt <= branch_target;
         lp <= branch_pointer;
      end
      if (arh) begin
         es <= ls;
         et <= lt;
         ep <= lp;
      end
      if (!aresetn) begin
         {ps, pt, seen, hv, fs, ft} <= '0;
      end else begin
         seen <= seen | target_fetch_strobe;
         hv <= hv | branch_strobe;
         fs <= target_fetch_strobe | (fs & !branch_strobe & !(arh && s_axi_araddr == 8'h10));
         ft <= target_fetch_strobe | (ft & !branch_strobe & !(arh && s_axi_araddr == 8'h20));
         if (branch_strobe | target_fetch_strobe) begin
            ps <= '0;
            pt <= '0;
         end else if (arh && grp == 4'h1) begin
            ps[s_axi_araddr[3:2]] <= 1'h1;
         end else if (arh && grp == 4'h2) begin
            pt[s_axi_araddr[3:2]] <= 1'h1;
         end
      end
   end
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_RD_LATENCY: assert property (arh |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_UNMAPPED: assert property (arh && grp >= 4'h3 |=> s_axi_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RESERVED: assert property (arh && grp == 4'h0 |=> (s_axi_rdata & 32'hFFFF0F7F) == 32'h0)
      else $error("reserved flag bits set");
   AST_RESET_FLAGS: assert property (arh && grp == 4'h0 && !seen |=> (s_axi_rdata & 32'h8080) == 32'h0)
      else $error("valid flag set without fetch");
   AST_SRC_CLEAR: assert property (arh && grp == 4'h0 && ps[s_axi_araddr[3:2]] |=> !s_axi_rdata[15])
      else $error("source flag not cleared by read");
   AST_TGT_CLEAR: assert property (arh && grp == 4'h0 && pt[s_axi_araddr[3:2]] |=> !s_axi_rdata[7])
      else $error("target flag not cleared by read");
   AST_FETCH_SET: assert property (arh && s_axi_araddr == 8'h00 |=> s_axi_rdata[15] == $past(fs) && s_axi_rdata[7] == $past(ft))
      else $error("valid flags wrong after fetch");
   AST_SRC_CAPT: assert property (arh && hv && s_axi_araddr == 8'h10 |=> s_axi_rdata == es)
      else $error("source entry 0 wrong");
   AST_TGT_CAPT: assert property (arh && hv && s_axi_araddr == 8'h20 |=> s_axi_rdata == et)
      else $error("target entry 0 wrong");
   AST_PTR_CAPT: assert property (arh && hv && s_axi_araddr == 8'h00 |=> s_axi_rdata[14:12] == ep)
      else $error("pointer of entry 0 wrong");
endmodule
`default_nettype wire

// ### testbench/btf_pipe_model.sv
// Pipeline stand-in: branch events, then a target fetch after a delay.
// Assumes the bench requests events through go, fetch and fdly.
`timescale 1ns/100ps
`default_nettype none
module btf_pipe_model
   import btf_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic fetch,
   input wire logic [1:0] fdly,
   input wire logic [BTF_ADDR_W-1:0] src,
   input wire logic [BTF_ADDR_W-1:0] tgt,
   input wire logic [BTF_PTR_W-1:0] ptr,
   output logic branch_strobe,
   output logic [BTF_ADDR_W-1:0] branch_source,
   output logic [BTF_ADDR_W-1:0] branch_target,
   output logic [BTF_PTR_W-1:0] branch_pointer,
   output logic target_fetch_strobe
);
////////////////////////////////////////
   logic [2:0] cnt = 3'h0;
   initial begin
      branch_strobe = 1'h0;
      target_fetch_strobe = 1'h0;
      branch_source = 32'h0;
      branch_target = 32'h0;
      branch_pointer = 3'h0;
   end
   // Idle data lines toggle so a stray sample never looks right
   always @(posedge aclk) begin
      branch_strobe <= go & aresetn;
      target_fetch_strobe <= aresetn & (cnt == 3'h1);
      if (go) begin
         branch_source <= src;
         branch_target <= tgt;
         branch_pointer <= ptr;
         cnt <= fetch ? {1'h0, fdly} + 3'h1 : 3'h0;
      end else begin
         branch_source <= ~branch_source;
         branch_target <= ~branch_target;
         branch_pointer <= ~branch_pointer;
         if (cnt != 3'h0) cnt <= cnt - 3'h1;
      end
   end
endmodule
`default_nettype wire

// ### testbench/test_branch_trace_fifo.sv
// Bench of btf_top: register reads and writes over AXI4-Lite, branches via model.
// Assumes btf_top_monitor and btf_pipe_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_branch_trace_fifo
   import btf_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic go = 1'h0;
   logic fetch = 1'h0;
   logic [1:0] fdly = 2'h0;
   logic [31:0] src = 32'h0, tgt = 32'h0, wdata = 32'h0, rdata, branch_source, branch_target;
   logic [2:0] ptr = 3'h0, branch_pointer;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, branch_strobe, target_fetch_strobe;
   logic [1:0] bresp, rresp;
   int bad_count = 0;
   int compares = 0;
   btf_pipe_model pm_u (.aclk(aclk), .aresetn(aresetn), .go(go), .fetch(fetch), .fdly(fdly),
      .src(src), .tgt(tgt), .ptr(ptr), .branch_strobe(branch_strobe),
      .branch_source(branch_source), .branch_target(branch_target),
      .branch_pointer(branch_pointer), .target_fetch_strobe(target_fetch_strobe));
   btf_top dut_u (.aclk(aclk), .aresetn(aresetn), .branch_strobe(branch_strobe),
      .branch_source(branch_source), .branch_target(branch_target),
      .branch_pointer(branch_pointer), .target_fetch_strobe(target_fetch_strobe),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
////////////////////////////////////////
   initial begin
      forever #2 aclk = ~aclk;
   end
   task automatic end_sim;
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] er);
      int n;
      logic aw_take, w_take, b_seen;
      logic [1:0] b_code;
      n = 0;
      b_code = 2'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= 32'hFFFFFFFF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         // Handshakes sampled settled, acted on at the next rising edge
         @(negedge aclk);
         aw_take = awvalid && awready;
         w_take = wvalid && wready;
         b_seen = bvalid;
         b_code = bresp;
         @(posedge aclk);
         if (aw_take) awvalid <= 1'h0;
         if (w_take) wvalid <= 1'h0;
         if (b_seen) break;
         n++;
         if (n > 50) begin
            bad_count++;
            end_sim();
         end
      end
      bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, b_code});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
      int n;
      logic ar_take, r_seen;
      logic [31:0] r_data;
      logic [1:0] r_code;
      n = 0;
      r_data = 32'h0;
      r_code = 2'h0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(negedge aclk);
         ar_take = arvalid && arready;
         r_seen = rvalid;
         r_data = rdata;
         r_code = rresp;
         @(posedge aclk);
         if (ar_take) arvalid <= 1'h0;
         if (r_seen) break;
         n++;
         if (n > 50) begin
            bad_count++;
            end_sim();
         end
      end
      rready <= 1'h0;
      chk("rdata", e, r_data & m);
      chk("rresp", {30'h0, er}, {30'h0, r_code});
   endtask
   // Branches on n back-to-back cycles, source and pointer step by one
   task automatic branch(input logic [31:0] s, input logic [2:0] p, input logic f,
      input logic [1:0] dl, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         go <= 1'h1;
         src <= s + i;
         tgt <= ~(s + i);
         ptr <= p + i[2:0];
         fetch <= f;
         fdly <= dl;
      end
      @(posedge aclk);
      go <= 1'h0;
      repeat (6) @(posedge aclk);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         rchk(8'(4 * i), 32'h0, 32'hFFFF8FFF, BTF_RESP_OKAY);
      end
      for (int k = 0; k < 5; k++) begin
         branch(32'hA5000000 + k, 3'(k + 3), 1'h1, 2'(k), 1);
      end
      for (int i = 0; i < 4; i++) begin
         rchk(8'(4 * i), 32'h8080 | ((7 - i) % 8) << 12, 32'hFFFFFFFF, BTF_RESP_OKAY);
         rchk(8'h10 + 8'(4 * i), 32'hA5000004 - i, 32'hFFFFFFFF, BTF_RESP_OKAY);
         rchk(8'h20 + 8'(4 * i), ~(32'hA5000004 - i), 32'hFFFFFFFF, BTF_RESP_OKAY);
         rchk(8'(4 * i), 32'h0000, 32'h80FF, BTF_RESP_OKAY);
      end
      branch(32'hC0000000, 3'h2, 1'h0, 2'h0, 2);
      rchk(8'h10, 32'hC0000001, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h14, 32'hC0000000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h18, 32'hA5000004, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h00, 32'h3000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h04, 32'h2000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      wr(8'h00, BTF_RESP_OKAY);
      wr(8'h10, BTF_RESP_OKAY);
      wr(8'h44, BTF_RESP_SLVERR);
      rchk(8'h00, 32'h3000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h10, 32'hC0000001, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h30, 32'h0, 32'hFFFFFFFF, BTF_RESP_SLVERR);
      branch(32'hD0000000, 3'h5, 1'h1, 2'h3, 1);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rchk(8'h00, 32'h5000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h20, 32'h2FFFFFFF, 32'hFFFFFFFF, BTF_RESP_OKAY);
      rchk(8'h10, 32'hD0000000, 32'hFFFFFFFF, BTF_RESP_OKAY);
      end_sim();
   end
endmodule
bind btf_top btf_top_monitor #(.DEPTH(DEPTH)) mon_u (.aclk(aclk), .aresetn(aresetn),
   .branch_strobe(branch_strobe), .branch_source(branch_source),
   .branch_target(branch_target), .branch_pointer(branch_pointer),
   .target_fetch_strobe(target_fetch_strobe), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire
